// ### rtl/pli_pkg.sv
// Constants and types shared by the port lamp indicator engine
package pli_pkg;
    localparam int PORT_COUNT = 9;
    localparam int CLK_MHZ = 125;
    localparam int BLINK_PHASE_MS = 105;
    localparam int REFRESH_MS = 10;
    localparam int BLINK_PHASE_CYCLES = BLINK_PHASE_MS * 1000 * CLK_MHZ;
    localparam int REFRESH_CYCLES = REFRESH_MS * 1000 * CLK_MHZ;
    localparam int SHIFT_HALF_CYCLES = 4;
    localparam int CTRL_WIDTH = 16;
    localparam int CTRL_SERIAL_EN_BIT = 12;
    localparam int CTRL_SERIAL_TYPE_BIT = 11;
    localparam logic CTRL_SERIAL_EN_RESET = 1'h0;
    localparam logic CTRL_SERIAL_TYPE_RESET = 1'h0;
    localparam logic SERIAL_TYPE_LINK_ONLY = 1'h1;
    localparam int FRAME_BITS_LINK_ONLY = PORT_COUNT;
    localparam int FRAME_BITS_FULL = 3 * PORT_COUNT;

    typedef enum logic [1:0]
    {
        PATTERN_0 = 2'b00,
        PATTERN_1 = 2'b01,
        PATTERN_2 = 2'b10,
        PATTERN_3 = 2'b11
    } pli_pattern_type;

    typedef enum logic [1:0]
    {
        SHIFT_IDLE = 2'b00,
        SHIFT_LOW = 2'b01,
        SHIFT_HIGH = 2'b10
    } pli_shift_state_type;
endpackage

// ### rtl/pli_blink.sv
// Off-then-on blink sequencer for one event source (activity or collision) of one port
`timescale 1ns/1ps
module pli_blink
    import pli_pkg::*;
#(
    parameter int PHASE_CYCLES = BLINK_PHASE_CYCLES
)
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic trigger_in,
    output logic busy_out,
    output logic on_out
);
    localparam int CW = $clog2(PHASE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(PHASE_CYCLES - 1);

    logic [CW-1:0] count;
    logic busy;
    logic on_phase;
    logic seen;

    generate
        if (PHASE_CYCLES < 1)
        begin : g_bad
            $error("pli_blink: PHASE_CYCLES must be at least one");
        end
    endgenerate

    // Own counter per sequencer, so a new blink always opens with a full off phase
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            count <= '0;
            busy <= 1'b0;
            on_phase <= 1'b0;
            seen <= 1'b0;
        end
        else if (!busy)
        begin
            count <= '0;
            on_phase <= 1'b0;
            seen <= 1'b0;
            busy <= trigger_in;
        end
        else if (count == LAST)
        begin
            count <= '0;
            if (!on_phase)
            begin
                on_phase <= 1'b1;
                seen <= seen | trigger_in;
            end
            else
            begin
                // Another cycle only if the event was seen during this one
                on_phase <= 1'b0;
                busy <= seen | trigger_in;
                seen <= 1'b0;
            end
        end
        else
        begin
            count <= count + 1'b1;
            seen <= seen | trigger_in;
        end
    end

    assign busy_out = busy;
    assign on_out = on_phase;
endmodule

// ### rtl/pli_lamp_engine.sv
// Port lamp indicator engine: parallel lamp patterns and serial lamp shifter
`timescale 1ns/1ps
module pli_lamp_engine
    import pli_pkg::*;
#(
    parameter int BLINK_CYCLES = BLINK_PHASE_CYCLES,
    parameter int REFRESH_PERIOD_CYCLES = REFRESH_CYCLES,
    parameter int HALF_BIT_CYCLES = SHIFT_HALF_CYCLES
)
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [1:0] lamp_pattern_select_in,
    input wire logic ctrl_write_in,
    input wire logic [CTRL_WIDTH-1:0] ctrl_wdata_in,
    input wire logic [PORT_COUNT-1:0] port_link_up_in,
    input wire logic [PORT_COUNT-1:0] port_speed100_in,
    input wire logic [PORT_COUNT-1:0] port_full_duplex_in,
    input wire logic [PORT_COUNT-1:0] port_activity_in,
    input wire logic [PORT_COUNT-1:0] port_collision_in,
    output logic [CTRL_WIDTH-1:0] ctrl_rdata_out,
    output logic [PORT_COUNT-1:0] link_lamp_out,
    output logic [PORT_COUNT-1:0] speed_lamp_out,
    output logic [PORT_COUNT-1:0] duplex_lamp_out,
    output logic lamp_shift_clk_out,
    output logic lamp_shift_data_out,
    output logic serial_frame_busy_out
);
    localparam int SYNC_W = 2 + 5 * PORT_COUNT;
    localparam int RW = $clog2(REFRESH_PERIOD_CYCLES + 1);
    localparam int HW = $clog2(HALF_BIT_CYCLES + 1);
    localparam int BW = $clog2(FRAME_BITS_FULL + 1);
    localparam logic [RW-1:0] REFRESH_LAST = RW'(REFRESH_PERIOD_CYCLES - 1);
    localparam logic [HW-1:0] HALF_LAST = HW'(HALF_BIT_CYCLES - 1);
    localparam logic [BW-1:0] BITS_LINK_ONLY = BW'(FRAME_BITS_LINK_ONLY);
    localparam logic [BW-1:0] BITS_FULL = BW'(FRAME_BITS_FULL);

    generate
        if (HALF_BIT_CYCLES < 1 || BLINK_CYCLES < 1)
        begin : g_bad_timing
            $error("pli_lamp_engine: shift and blink counts must be at least one");
        end
        if (REFRESH_PERIOD_CYCLES <= 2 * HALF_BIT_CYCLES * FRAME_BITS_FULL)
        begin : g_bad_refresh
            $error("pli_lamp_engine: refresh period shorter than one frame");
        end
    endgenerate

    // Lamp level: 1 is dark, 0 is lit; a flash shows its off phase first
    function automatic logic flash_lamp(input logic ok, input logic busy, input logic on);
        logic lamp;
        lamp = 1'b1;
        if (ok)
        begin
            lamp = busy ? ~on : 1'b0;
        end
        return lamp;
    endfunction

    // Duplex style lamp: half dark, full lit, collision flashes
    function automatic logic duplex_level(input logic full, input logic busy, input logic on);
        logic lamp;
        lamp = ~full;
        if (busy)
        begin
            lamp = ~on;
        end
        return lamp;
    endfunction

    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_stable;
    pli_pattern_type pattern;
    logic [PORT_COUNT-1:0] link_up;
    logic [PORT_COUNT-1:0] speed100;
    logic [PORT_COUNT-1:0] full_duplex;
    logic [PORT_COUNT-1:0] activity;
    logic [PORT_COUNT-1:0] collision;
    logic [PORT_COUNT-1:0] act_busy;
    logic [PORT_COUNT-1:0] act_on;
    logic [PORT_COUNT-1:0] col_busy;
    logic [PORT_COUNT-1:0] col_on;

    logic serial_lamp_enable;
    logic serial_lamp_type;

    logic [PORT_COUNT-1:0] next_link_lamp;
    logic [PORT_COUNT-1:0] next_speed_lamp;
    logic [PORT_COUNT-1:0] next_duplex_lamp;
    logic [PORT_COUNT-1:0] link_lamp;
    logic [PORT_COUNT-1:0] speed_lamp;
    logic [PORT_COUNT-1:0] duplex_lamp;

    logic [RW-1:0] refresh_count;
    logic refresh_tick;
    pli_shift_state_type shift_state;
    logic [HW-1:0] half_count;
    logic [BW-1:0] bits_left;
    logic [FRAME_BITS_FULL-1:0] shift_reg;
    logic shift_clk;
    logic shift_data;

    // Port status arrives from the transceivers' own timing; two stages first
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sync_meta <= '0;
            sync_stable <= '0;
        end
        else
        begin
            sync_meta <= {lamp_pattern_select_in, port_link_up_in, port_speed100_in,
                          port_full_duplex_in, port_activity_in, port_collision_in};
            sync_stable <= sync_meta;
        end
    end

    assign pattern = pli_pattern_type'(sync_stable[SYNC_W-1 -: 2]);
    assign link_up = sync_stable[5*PORT_COUNT-1 -: PORT_COUNT];
    assign speed100 = sync_stable[4*PORT_COUNT-1 -: PORT_COUNT];
    assign full_duplex = sync_stable[3*PORT_COUNT-1 -: PORT_COUNT];
    assign activity = sync_stable[2*PORT_COUNT-1 -: PORT_COUNT];
    assign collision = sync_stable[PORT_COUNT-1 -: PORT_COUNT];

    // Single shared copy; no per-port address decoding here
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            serial_lamp_enable <= CTRL_SERIAL_EN_RESET;
            serial_lamp_type <= CTRL_SERIAL_TYPE_RESET;
        end
        else if (ctrl_write_in)
        begin
            serial_lamp_enable <= ctrl_wdata_in[CTRL_SERIAL_EN_BIT];
            serial_lamp_type <= ctrl_wdata_in[CTRL_SERIAL_TYPE_BIT];
        end
    end

    always_comb
    begin
        ctrl_rdata_out = '0;
        ctrl_rdata_out[CTRL_SERIAL_EN_BIT] = serial_lamp_enable;
        ctrl_rdata_out[CTRL_SERIAL_TYPE_BIT] = serial_lamp_type;
    end

    // Two sequencers per port, same period, free phase per port
    genvar p;
    generate
        for (p = 0; p < PORT_COUNT; p++)
        begin : g_port
            pli_blink #(.PHASE_CYCLES(BLINK_CYCLES)) u_act_blink
            (
                .sys_clk_in(sys_clk_in),
                .rstn_in(rstn_in),
                .trigger_in(link_up[p] & activity[p]),
                .busy_out(act_busy[p]),
                .on_out(act_on[p])
            );
            pli_blink #(.PHASE_CYCLES(BLINK_CYCLES)) u_col_blink
            (
                .sys_clk_in(sys_clk_in),
                .rstn_in(rstn_in),
                .trigger_in(collision[p]),
                .busy_out(col_busy[p]),
                .on_out(col_on[p])
            );
        end
    endgenerate

    // Same selector evaluates all nine ports at once
    always_comb
    begin
        next_link_lamp = '1;
        next_speed_lamp = '1;
        next_duplex_lamp = '1;
        for (int i = 0; i < PORT_COUNT; i++)
        begin
            case (pattern)
                PATTERN_0:
                begin
                    next_link_lamp[i] = flash_lamp(link_up[i] & speed100[i],
                                                   act_busy[i], act_on[i]);
                    next_speed_lamp[i] = flash_lamp(link_up[i], act_busy[i], act_on[i]);
                    next_duplex_lamp[i] = ~link_up[i] | speed100[i];
                end
                PATTERN_1:
                begin
                    next_link_lamp[i] = ~link_up[i];
                    next_speed_lamp[i] = flash_lamp(link_up[i], act_busy[i], act_on[i]);
                    next_duplex_lamp[i] = duplex_level(full_duplex[i],
                                                       col_busy[i], col_on[i]);
                end
                PATTERN_2:
                begin
                    next_link_lamp[i] = flash_lamp(link_up[i] & speed100[i],
                                                   act_busy[i], act_on[i]);
                    next_speed_lamp[i] = duplex_level(full_duplex[i],
                                                      col_busy[i], col_on[i]);
                    next_duplex_lamp[i] = flash_lamp(link_up[i] & ~speed100[i],
                                                     act_busy[i], act_on[i]);
                end
                default:
                begin
                    next_link_lamp[i] = flash_lamp(link_up[i], act_busy[i], act_on[i]);
                    next_speed_lamp[i] = ~speed100[i];
                    next_duplex_lamp[i] = duplex_level(full_duplex[i],
                                                       col_busy[i], col_on[i]);
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            link_lamp <= '1;
            speed_lamp <= '1;
            duplex_lamp <= '1;
        end
        else
        begin
            link_lamp <= next_link_lamp;
            speed_lamp <= next_speed_lamp;
            duplex_lamp <= next_duplex_lamp;
        end
    end

    assign link_lamp_out = link_lamp;
    assign speed_lamp_out = speed_lamp;
    assign duplex_lamp_out = duplex_lamp;

    // Refresh timer runs only while serial output is on
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            refresh_count <= '0;
            refresh_tick <= 1'b0;
        end
        else if (!serial_lamp_enable)
        begin
            refresh_count <= '0;
            refresh_tick <= 1'b0;
        end
        else if (refresh_count == REFRESH_LAST)
        begin
            refresh_count <= '0;
            refresh_tick <= 1'b1;
        end
        else
        begin
            refresh_count <= refresh_count + 1'b1;
            refresh_tick <= 1'b0;
        end
    end

    // Data changes while the shift clock is low, so decoders latch on the rise
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            shift_state <= SHIFT_IDLE;
            half_count <= '0;
            bits_left <= '0;
            shift_reg <= '0;
            shift_clk <= 1'b0;
            shift_data <= 1'b0;
        end
        else
        begin
            case (shift_state)
                SHIFT_IDLE:
                begin
                    shift_clk <= 1'b0;
                    shift_data <= 1'b0;
                    half_count <= '0;
                    if (refresh_tick && serial_lamp_enable)
                    begin
                        shift_state <= SHIFT_LOW;
                        if (serial_lamp_type == SERIAL_TYPE_LINK_ONLY)
                        begin
                            // Port 8 first within each group
                            shift_reg <= {link_lamp, {(2*PORT_COUNT){1'b0}}};
                            bits_left <= BITS_LINK_ONLY;
                            shift_data <= link_lamp[PORT_COUNT-1];
                        end
                        else
                        begin
                            shift_reg <= {link_lamp, speed_lamp, duplex_lamp};
                            bits_left <= BITS_FULL;
                            shift_data <= link_lamp[PORT_COUNT-1];
                        end
                    end
                end
                SHIFT_LOW:
                begin
                    if (half_count == HALF_LAST)
                    begin
                        half_count <= '0;
                        shift_clk <= 1'b1;
                        shift_state <= SHIFT_HIGH;
                    end
                    else
                    begin
                        half_count <= half_count + 1'b1;
                    end
                end
                SHIFT_HIGH:
                begin
                    if (half_count == HALF_LAST)
                    begin
                        half_count <= '0;
                        shift_clk <= 1'b0;
                        bits_left <= bits_left - 1'b1;
                        if (bits_left == BW'(1))
                        begin
                            shift_data <= 1'b0;
                            shift_state <= SHIFT_IDLE;
                        end
                        else
                        begin
                            shift_reg <= {shift_reg[FRAME_BITS_FULL-2:0], 1'b0};
                            shift_data <= shift_reg[FRAME_BITS_FULL-2];
                            shift_state <= SHIFT_LOW;
                        end
                    end
                    else
                    begin
                        half_count <= half_count + 1'b1;
                    end
                end
                default:
                begin
                    shift_state <= SHIFT_IDLE;
                end
            endcase
        end
    end

    assign lamp_shift_clk_out = shift_clk;
    assign lamp_shift_data_out = shift_data;
    assign serial_frame_busy_out = (shift_state != SHIFT_IDLE);
endmodule

// ### bench/pli_lamp_engine_properties.sv
// Port-level assertions for the lamp engine
`timescale 1ns/1ps
module pli_lamp_engine_properties
    import pli_pkg::*;
#(
    parameter int BLINK_CYCLES = BLINK_PHASE_CYCLES,
    parameter int REFRESH_PERIOD_CYCLES = REFRESH_CYCLES,
    parameter int HALF_BIT_CYCLES = SHIFT_HALF_CYCLES
)
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [1:0] lamp_pattern_select_in,
    input wire logic ctrl_write_in,
    input wire logic [CTRL_WIDTH-1:0] ctrl_wdata_in,
    input wire logic [PORT_COUNT-1:0] port_link_up_in,
    input wire logic [PORT_COUNT-1:0] port_speed100_in,
    input wire logic [PORT_COUNT-1:0] port_full_duplex_in,
    input wire logic [PORT_COUNT-1:0] port_activity_in,
    input wire logic [PORT_COUNT-1:0] port_collision_in,
    input wire logic [CTRL_WIDTH-1:0] ctrl_rdata_out,
    input wire logic [PORT_COUNT-1:0] link_lamp_out,
    input wire logic [PORT_COUNT-1:0] speed_lamp_out,
    input wire logic [PORT_COUNT-1:0] duplex_lamp_out,
    input wire logic lamp_shift_clk_out,
    input wire logic lamp_shift_data_out,
    input wire logic serial_frame_busy_out
);
    logic [28:0] prev;
    logic [2:0] calm;
    logic [6:0] quiet;
    logic [31:0] gap;
    logic seen;
    logic [5:0] nbits;
    logic busy_q;
    logic sclk_q;
    logic hush;
    logic [1:0] s;
    logic [8:0] lk;
    logic [8:0] sp;
    logic [8:0] fd;
    assign {s, lk, sp, fd} = prev;
    // A retriggered flash may run two sequences past the last event
    assign hush = int'(quiet) > 4 * BLINK_CYCLES + 8;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            prev <= 29'h0;
            calm <= 3'h0;
            quiet <= 7'h00;
        end
        else
        begin
            prev <= {lamp_pattern_select_in, port_link_up_in, port_speed100_in,
                port_full_duplex_in};
            if ({lamp_pattern_select_in, port_link_up_in, port_speed100_in,
                port_full_duplex_in} != prev)
                calm <= 3'h0;
            else if (calm != 3'h7)
                calm <= calm + 3'h1;
            if (|{port_activity_in, port_collision_in})
                quiet <= 7'h00;
            else if (quiet != 7'h7f)
                quiet <= quiet + 7'h01;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            busy_q <= 1'h0;
            sclk_q <= 1'h0;
            nbits <= 6'h00;
            gap <= 32'h0;
            seen <= 1'h0;
        end
        else
        begin
            busy_q <= serial_frame_busy_out;
            sclk_q <= lamp_shift_clk_out;
            if (serial_frame_busy_out && !busy_q)
            begin
                nbits <= 6'h00;
                gap <= 32'h1;
            end
            else
            begin
                nbits <= nbits + 6'(lamp_shift_clk_out && !sclk_q);
                gap <= gap + 32'h1;
            end
            // A control write can stop or restart the refresh timer
            if (ctrl_write_in)
                seen <= 1'h0;
            else if (serial_frame_busy_out && !busy_q)
                seen <= 1'h1;
        end
    end
    a_link_lamp_steady:
        assert property (calm > 3'h3 && hush |-> link_lamp_out == (s[0] ? ~lk : ~(lk & sp)))
        else $error("link lamp steady level wrong");
    a_duplex_lamp_steady:
        assert property (calm > 3'h3 && hush |-> duplex_lamp_out == (s == 2'h0 ? ~lk | sp
            : s == 2'h2 ? ~(lk & ~sp) : ~fd))
        else $error("duplex lamp steady level wrong");
    a_speed_lamp_steady:
        assert property (calm > 3'h3 && hush && s[1] |-> speed_lamp_out == (s[0] ? ~sp : ~fd))
        else $error("speed lamp steady level wrong");
    a_blink_off_phase:
        assert property ($rose(link_lamp_out[0]) && s == 2'h3 && lk[0] && calm > 3'h3
            |-> link_lamp_out[0] [*8])
        else $error("blink dark phase cut short");
    a_shift_idle_low:
        assert property (!serial_frame_busy_out |-> !lamp_shift_clk_out && !lamp_shift_data_out)
        else $error("shift pins not idle low");
    a_bit_hold_high:
        assert property ($rose(lamp_shift_clk_out) |-> $stable(lamp_shift_data_out)
            ##1 (lamp_shift_clk_out && $stable(lamp_shift_data_out)) [*4] ##1 !lamp_shift_clk_out)
        else $error("shift data moved while clock high");
    a_ctrl_readback:
        assert property (ctrl_write_in |=> ctrl_rdata_out == ($past(ctrl_wdata_in) & 16'h1800))
        else $error("control readback wrong");
    a_refresh_period:
        assert property ($rose(serial_frame_busy_out) && seen |-> gap == REFRESH_PERIOD_CYCLES)
        else $error("frame spacing wrong");
    a_frame_bit_count:
        assert property ($fell(serial_frame_busy_out)
            |-> nbits == (ctrl_rdata_out[11] ? 6'h09 : 6'h1b))
        else $error("frame bit count wrong");
    c_short_frame: cover property ($rose(serial_frame_busy_out) && ctrl_rdata_out[11]);
    c_blink: cover property ($rose(link_lamp_out[0]));
    c_write: cover property (ctrl_write_in);
endmodule

// ### bench/pli_shift_decoder.sv
// Behavioural shift-register lamp decoder on the serial pins
`timescale 1ns/1ps
module pli_shift_decoder
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic shift_clk_in,
    input wire logic shift_data_in,
    input wire logic frame_busy_in,
    output logic [26:0] frame_out,
    output logic [5:0] bits_out,
    output logic [7:0] frames_out
);
    logic clk_q;
    logic busy_q;
    // Shifts on the rising shift clock, like a chain of TTL registers
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            clk_q <= 1'h0;
            busy_q <= 1'h0;
            frame_out <= 27'h0;
            bits_out <= 6'h00;
            frames_out <= 8'h00;
        end
        else
        begin
            clk_q <= shift_clk_in;
            busy_q <= frame_busy_in;
            if (frame_busy_in && !busy_q)
            begin
                frame_out <= 27'h0;
                bits_out <= 6'h00;
            end
            else if (shift_clk_in && !clk_q)
            begin
                frame_out <= {frame_out[25:0], shift_data_in};
                bits_out <= bits_out + 6'h01;
            end
            if (!frame_busy_in && busy_q)
                frames_out <= frames_out + 8'h01;
        end
    end
endmodule

// ### bench/testbench.sv
// Self-checking bench for the port lamp indicator engine
`timescale 1ns/1ps
module testbench;
    localparam int BLINK = 20;
    localparam int REFRESH = 400;
    logic sys_clk_in;
    logic rstn_in;
    logic [1:0] lamp_pattern_select_in;
    logic ctrl_write_in;
    logic [15:0] ctrl_wdata_in;
    logic [8:0] port_link_up_in;
    logic [8:0] port_speed100_in;
    logic [8:0] port_full_duplex_in;
    logic [8:0] port_activity_in;
    logic [8:0] port_collision_in;
    logic [15:0] ctrl_rdata_out;
    logic [8:0] link_lamp_out;
    logic [8:0] speed_lamp_out;
    logic [8:0] duplex_lamp_out;
    logic lamp_shift_clk_out;
    logic lamp_shift_data_out;
    logic serial_frame_busy_out;
    logic [26:0] frame;
    logic [5:0] nbits;
    logic [7:0] nframes;
    int errors;
    int tests_run;
    pli_lamp_engine #(
        .BLINK_CYCLES(BLINK),
        .REFRESH_PERIOD_CYCLES(REFRESH),
        .HALF_BIT_CYCLES(5)
    ) pli_lamp_engine_inst (.*);
    pli_shift_decoder pli_shift_decoder_inst (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .shift_clk_in(lamp_shift_clk_out),
        .shift_data_in(lamp_shift_data_out),
        .frame_busy_in(serial_frame_busy_out),
        .frame_out(frame),
        .bits_out(nbits),
        .frames_out(nframes)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Steady lamp levels, 1 dark; speed of patterns 0 and 1 has no steady meaning
    function automatic logic [26:0] lamp_exp(input logic [1:0] s);
        logic [8:0] l100;
        logic [8:0] l10;
        l100 = port_link_up_in & port_speed100_in;
        l10 = port_link_up_in & ~port_speed100_in;
        case (s)
            2'h0: return {~l100, 9'h1ff, ~port_link_up_in | port_speed100_in};
            2'h1: return {~port_link_up_in, 9'h1ff, ~port_full_duplex_in};
            2'h2: return {~l100, ~port_full_duplex_in, ~l10};
            default: return {~port_link_up_in, ~port_speed100_in, ~port_full_duplex_in};
        endcase
    endfunction
    function automatic int first_one(input logic [99:0] h);
        for (int i = 0; i < 100; i++)
            if (h[i] === 1'b1)
                return i;
        return 200;
    endfunction
    task automatic write_ctrl(input logic [15:0] d);
        @(negedge sys_clk_in);
        ctrl_write_in = 1'b1;
        ctrl_wdata_in = d;
        @(negedge sys_clk_in);
        ctrl_write_in = 1'b0;
    endtask
    task automatic t_reset();
        repeat (4) @(posedge sys_clk_in);
        #1;
        check(ctrl_rdata_out, 32'h0);
        check({link_lamp_out, speed_lamp_out, duplex_lamp_out}, 32'h7ffffff);
        check({lamp_shift_clk_out, lamp_shift_data_out, serial_frame_busy_out}, 32'h0);
        @(negedge sys_clk_in);
        rstn_in = 1'b1;
    endtask
    task automatic t_ctrl();
        write_ctrl(16'hffff);
        check(ctrl_rdata_out, 32'h1800);
        write_ctrl(16'h0000);
        check(ctrl_rdata_out, 32'h0);
    endtask
    task automatic t_patterns();
        logic [26:0] e;
        for (int s = 0; s < 4; s++)
        begin
            @(negedge sys_clk_in);
            lamp_pattern_select_in = 2'(s);
            repeat (s == 0 ? 100 : 12) @(negedge sys_clk_in);
            e = lamp_exp(2'(s));
            check(link_lamp_out, e[26:18]);
            check(duplex_lamp_out, e[8:0]);
            if (s > 1)
                check(speed_lamp_out, e[17:9]);
        end
    endtask
    task automatic t_blink();
        logic [99:0] h0;
        logic [99:0] h1;
        logic [99:0] hd;
        int r;
        int rd;
        int mis;
        for (int i = 0; i < 100; i++)
        begin
            @(negedge sys_clk_in);
            h0[i] = link_lamp_out[0];
            h1[i] = link_lamp_out[1];
            hd[i] = duplex_lamp_out[2];
            port_activity_in = {7'h00, i == 3, i == 0 || i == 10};
            port_collision_in = {6'h00, i == 0, 2'h0};
        end
        r = first_one(h0);
        rd = first_one(hd);
        check(r < 8 && rd < 8, 32'h1);
        mis = 0;
        for (int i = 0; i < 100; i++)
        begin
            // Second event lands in the dark phase, so the sequence runs twice
            mis += int'(h0[i] !== (i >= r && i < r + BLINK
                || i >= r + 2 * BLINK && i < r + 3 * BLINK));
            mis += int'(h1[i] !== (i >= r + 3 && i < r + 3 + BLINK));
            mis += int'(hd[i] !== (i >= rd && i < rd + BLINK));
        end
        check(mis, 32'h0);
    endtask
    task automatic t_serial(input logic typ);
        logic [26:0] e;
        logic [7:0] f0;
        e = lamp_exp(2'h3);
        write_ctrl({3'h0, 1'b1, typ, 11'h000});
        f0 = nframes;
        for (int i = 0; i < 1000 && nframes == f0; i++)
            @(negedge sys_clk_in);
        check(nbits, typ ? 32'h09 : 32'h1b);
        check(frame, typ ? {18'h0, e[26:18]} : e);
        f0 = nframes;
        repeat (3 * REFRESH) @(negedge sys_clk_in);
        check(nframes - f0, 32'h3);
    endtask
    task automatic t_quiet(input logic typ);
        logic [7:0] f0;
        write_ctrl({4'h0, typ, 11'h000});
        repeat (300) @(negedge sys_clk_in);
        f0 = nframes;
        repeat (2 * REFRESH) @(negedge sys_clk_in);
        check(nframes - f0, 32'h0);
    endtask
    initial
    begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    initial
    begin
        #(8 * 12000);
        errors++;
        report_and_stop();
    end
    initial
    begin
        errors = 0;
        tests_run = 0;
        rstn_in = 1'b0;
        lamp_pattern_select_in = 2'h0;
        ctrl_write_in = 1'b0;
        ctrl_wdata_in = 16'h0000;
        port_link_up_in = 9'h1b7;
        port_speed100_in = 9'h0f3;
        port_full_duplex_in = 9'h0ac;
        port_activity_in = 9'h000;
        port_collision_in = 9'h000;
        t_reset();
        t_ctrl();
        t_patterns();
        t_blink();
        t_serial(1'b0);
        t_quiet(1'b0);
        t_serial(1'b1);
        t_quiet(1'b1);
        report_and_stop();
    end
endmodule
bind pli_lamp_engine pli_lamp_engine_properties #(
    .BLINK_CYCLES(BLINK_CYCLES),
    .REFRESH_PERIOD_CYCLES(REFRESH_PERIOD_CYCLES),
    .HALF_BIT_CYCLES(HALF_BIT_CYCLES)
) pli_lamp_engine_properties_inst (.*);
